/* File: logic/vlm_regs.svh */
// Timing and field constants of the vibration limit alarm monitor
`ifndef VLM_REGS_SVH
`define VLM_REGS_SVH
`define VLM_CLK_HZ 20000000
`define VLM_TICK_MS 250
`define VLM_TICK_CYC ((`VLM_CLK_HZ / 1000) * `VLM_TICK_MS)
`define VLM_MEAS_Q 12
`define VLM_SET_HP1_Q 7
`define VLM_SET_HP3_Q 4
`define VLM_SET_HP10_Q 5
`define VLM_SET_SPEC_Q 7
`define VLM_SET_INT_Q 24
`define VLM_SET_LIN_Q 23
`define VLM_BRG_SET_Q 11
`define VLM_BRG_MEAS_Q 5
`define VLM_DLY_MIN_S 1
`define VLM_DLY_MAX_S 99
`define VLM_Q_PER_S 4
`define VLM_LIM_MIN_PCT 10
`define VLM_LIM_MAX_PCT 100
`define VLM_LOG_DEPTH 99
`define VLM_HIST_CHAR 8'h48
`define VLM_EV_PWRUP 4'h1
`define VLM_EV_LIMIT 4'h2
`define VLM_EV_RESET 4'h3
`define VLM_EV_ERROR 4'h4
`endif

/* File: logic/vlm_pkg.sv */
// Types shared by the vibration limit alarm monitor
package vlm_pkg;
  typedef enum logic [1:0] {
    VLM_SETTLE_A,
    VLM_MEAS_A,
    VLM_SETTLE_B,
    VLM_MEAS_B
  } vlm_mux_e;
  typedef enum logic {
    VLM_BRG_SETTLE,
    VLM_BRG_MEAS
  } vlm_brg_e;
endpackage : vlm_pkg

/* File: logic/vlm_log_mem.sv */
// Event log memory with registered read data
`timescale 1ns/1ps
module vlm_log_mem #(
  parameter int DEPTH = 99,
  parameter int WIDTH = 24,
  parameter int AW = 7
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // Storage array
  logic [WIDTH-1:0] mem [DEPTH];
  // Write port and registered read
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : vlm_log_mem

/* File: logic/vlm_monitor.sv */
// Vibration limit alarm monitor supervisory logic
//
// Overview of operation
// - Two-channel mode alternates A/B with settling
// - Vibration measuring window lasts three seconds
// - Channel in its window checked every quarter second
// - Settling interval per function from table
// - Multiplex period is sum of channel cycles
// - Longest active function settling time wins
// - Bearing cycle independent: 2.75 s settle, 1.25 s
// - Three limits per channel: two vibration, one bearing
// - Limits outside 10..100 percent rejected with error
// - Delay 1..99 s; confirm after exceeding longer
// - Confirmed exceedance logs event, trips relay
// - Running delay pauses outside own window
// - Circular log of 99 entries, oldest dropped
// - Log power-up, limits, resets, internal errors
// - Entry: history letter, running number, event code
// - Log cleared at power-up and on command
// - Three relays, each with selectable limit set
// - Latching relay holds until reset arrives
// - Non-latching relay releases when value falls back
// - Relay normally energised or de-energised option
// - AND needs all assigned limits, OR any
// - Health fault freezes relays until fault clears and reset
`timescale 1ns/1ps
`include "vlm_regs.svh"
module vlm_monitor #(
  parameter int TICK_CYC = `VLM_TICK_CYC,
  parameter int VW = 10
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic two_chan,
  input wire logic [5:0] func_a,
  input wire logic [5:0] func_b,
  input wire logic [VW-1:0] meas_a,
  input wire logic [VW-1:0] meas_b,
  input wire logic [VW-1:0] brg_a,
  input wire logic [VW-1:0] brg_b,
  input wire logic [VW-1:0] range_a,
  input wire logic [VW-1:0] range_b,
  input wire logic [VW-1:0] brg_range,
  input wire logic lim_wr,
  input wire logic [2:0] lim_sel,
  input wire logic [VW-1:0] lim_val,
  input wire logic [6:0] lim_dly,
  input wire logic [5:0] lim_on,
  input wire logic [17:0] relay_map,
  input wire logic [2:0] relay_and,
  input wire logic [2:0] relay_latch,
  input wire logic [2:0] relay_energ,
  input wire logic relay_reset,
  input wire logic log_clear,
  input wire logic health_fault,
  input wire logic [6:0] log_rd_idx,
  output logic alarm_relay_one,
  output logic alarm_relay_two,
  output logic alarm_relay_three,
  output logic lim_err,
  output logic meas_chan_b,
  output logic meas_active,
  output logic brg_measuring,
  output logic [6:0] log_count,
  output logic [23:0] log_rd_data
);
  import vlm_pkg::*;

  // Command and mode pins (reset, clear, fault, two-channel) through two flip-flops
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {relay_reset, log_clear, health_fault, two_chan};
      sync2_reg <= sync1_reg;
    end
  end
  logic two_s, fault_s, clr_s, rst_s;
  assign {rst_s, clr_s, fault_s, two_s} = sync2_reg;

  // Edge detect on command pins
  logic clr_d_reg, rst_d_reg, fault_d_reg;
  logic clr_p, rst_p, fault_p;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clr_d_reg <= 1'b0;
      rst_d_reg <= 1'b0;
      fault_d_reg <= 1'b0;
    end else begin
      clr_d_reg <= clr_s;
      rst_d_reg <= rst_s;
      fault_d_reg <= fault_s;
    end
  end
  assign clr_p = clr_s & ~clr_d_reg;
  assign rst_p = rst_s & ~rst_d_reg;
  assign fault_p = fault_s & ~fault_d_reg;

  // Quarter second tick divider
  logic [31:0] div_reg, div_next;
  logic tick;
  always_comb begin
    div_next = div_reg + 32'h1;
    if (div_reg == 32'(TICK_CYC - 1)) begin
      div_next = 32'h0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_next;
    end
  end
  assign tick = (div_reg == 32'(TICK_CYC - 1));

  // Settling in quarter seconds, longest active function
  function automatic logic [4:0] settle_q(input logic [5:0] f);
    logic [4:0] s;
    s = 5'h1;
    if (f[0] && s < 5'(`VLM_SET_HP1_Q)) s = 5'(`VLM_SET_HP1_Q);
    if (f[1] && s < 5'(`VLM_SET_HP3_Q)) s = 5'(`VLM_SET_HP3_Q);
    if (f[2] && s < 5'(`VLM_SET_HP10_Q)) s = 5'(`VLM_SET_HP10_Q);
    if (f[3] && s < 5'(`VLM_SET_SPEC_Q)) s = 5'(`VLM_SET_SPEC_Q);
    if (f[4] && s < 5'(`VLM_SET_INT_Q)) s = 5'(`VLM_SET_INT_Q);
    if (f[5] && s < 5'(`VLM_SET_LIN_Q)) s = 5'(`VLM_SET_LIN_Q);
    return s;
  endfunction : settle_q

  // Channel multiplexer state
  vlm_mux_e mux_reg, mux_next;
  logic [4:0] mq_reg, mq_next;
  always_comb begin
    mux_next = mux_reg;
    mq_next = mq_reg;
    if (!two_s) begin
      // Single channel: A measured continuously
      mux_next = VLM_MEAS_A;
      mq_next = 5'h0;
    end else if (tick) begin
      mq_next = mq_reg + 5'h1;
      unique case (mux_reg)
        VLM_SETTLE_A: if (mq_reg + 5'h1 >= settle_q(func_a)) begin
          mux_next = VLM_MEAS_A;
          mq_next = 5'h0;
        end
        VLM_MEAS_A: if (mq_reg + 5'h1 >= 5'(`VLM_MEAS_Q)) begin
          mux_next = VLM_SETTLE_B;
          mq_next = 5'h0;
        end
        VLM_SETTLE_B: if (mq_reg + 5'h1 >= settle_q(func_b)) begin
          mux_next = VLM_MEAS_B;
          mq_next = 5'h0;
        end
        VLM_MEAS_B: if (mq_reg + 5'h1 >= 5'(`VLM_MEAS_Q)) begin
          mux_next = VLM_SETTLE_A;
          mq_next = 5'h0;
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mux_reg <= VLM_MEAS_A;
      mq_reg <= 5'h0;
    end else begin
      mux_reg <= mux_next;
      mq_reg <= mq_next;
    end
  end
  logic win_a, win_b;
  assign win_a = (mux_reg == VLM_MEAS_A);
  assign win_b = (mux_reg == VLM_MEAS_B);

  // Bearing cycle, independent of vibration mux
  vlm_brg_e brg_reg, brg_next;
  logic [3:0] bq_reg, bq_next;
  always_comb begin
    brg_next = brg_reg;
    bq_next = bq_reg;
    if (tick) begin
      bq_next = bq_reg + 4'h1;
      unique case (brg_reg)
        VLM_BRG_SETTLE: if (bq_reg + 4'h1 >= 4'(`VLM_BRG_SET_Q)) begin
          brg_next = VLM_BRG_MEAS;
          bq_next = 4'h0;
        end
        VLM_BRG_MEAS: if (bq_reg + 4'h1 >= 4'(`VLM_BRG_MEAS_Q)) begin
          brg_next = VLM_BRG_SETTLE;
          bq_next = 4'h0;
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      brg_reg <= VLM_BRG_SETTLE;
      bq_reg <= 4'h0;
    end else begin
      brg_reg <= brg_next;
      bq_reg <= bq_next;
    end
  end

  // Limit table: idx 0..2 channel A, 3..5 channel B
  logic [VW-1:0] lim_reg [6];
  logic [6:0] dly_reg [6];
  logic err_reg, err_next;
  logic [VW+6:0] lo_bnd, hi_bnd, val_x;
  logic [VW-1:0] rng_sel;
  logic lim_ok;
  always_comb begin
    rng_sel = (lim_sel == 3'd2 || lim_sel == 3'd5) ? brg_range :
              (lim_sel < 3'd3) ? range_a : range_b;
    val_x = (VW+7)'(lim_val) * (VW+7)'(100);
    lo_bnd = (VW+7)'(rng_sel) * (VW+7)'(`VLM_LIM_MIN_PCT);
    hi_bnd = (VW+7)'(rng_sel) * (VW+7)'(`VLM_LIM_MAX_PCT);
    lim_ok = (val_x >= lo_bnd) && (val_x <= hi_bnd) && (lim_sel < 3'd6) &&
             (lim_dly >= 7'(`VLM_DLY_MIN_S)) && (lim_dly <= 7'(`VLM_DLY_MAX_S));
    err_next = err_reg;
    if (lim_wr) begin
      err_next = ~lim_ok;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_reg <= 1'b0;
      for (int i = 0; i < 6; i++) begin
        lim_reg[i] <= '1;
        dly_reg[i] <= 7'(`VLM_DLY_MIN_S);
      end
    end else begin
      err_reg <= err_next;
      if (lim_wr && lim_ok) begin
        lim_reg[lim_sel] <= lim_val;
        dly_reg[lim_sel] <= lim_dly;
      end
    end
  end

  // Per-limit alarm delay and confirmation
  logic [5:0] over, win, conf_reg, conf_set;
  logic [8:0] dc_reg [6];
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_lim
      localparam bit IS_B = (g >= 3);
      localparam bit IS_BRG = (g % 3 == 2);
      logic [VW-1:0] val;
      logic [8:0] dc_next;
      assign val = IS_BRG ? (IS_B ? brg_b : brg_a) : (IS_B ? meas_b : meas_a);
      // Value compared every quarter second, gated by enable
      assign over[g] = lim_on[g] && (val > lim_reg[g]);
      assign win[g] = IS_BRG ? (brg_reg == VLM_BRG_MEAS) :
                      (!two_s ? !IS_B : (IS_B ? win_b : win_a));
      assign conf_set[g] = tick && win[g] && over[g] && !conf_reg[g] &&
                           (dc_reg[g] >= 9'(dly_reg[g]) * 9'(`VLM_Q_PER_S));
      always_comb begin
        dc_next = dc_reg[g];
        if (tick && win[g]) begin
          if (!over[g]) begin
            dc_next = 9'h0;
          end else if (!conf_reg[g]) begin
            dc_next = dc_reg[g] + 9'h1;
          end
        end
        // Outside window the count holds: paused delay
      end
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          dc_reg[g] <= 9'h0;
          conf_reg[g] <= 1'b0;
        end else begin
          dc_reg[g] <= dc_next;
          if (conf_set[g]) begin
            conf_reg[g] <= 1'b1;
          end else if (tick && win[g] && !over[g]) begin
            conf_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Relay combining, latching, health freeze
  logic [2:0] trip_reg, trip_next, cond;
  logic hold_reg, hold_next;
  always_comb begin
    hold_next = hold_reg;
    if (fault_s) begin
      hold_next = 1'b1;
    end else if (rst_p) begin
      hold_next = 1'b0;
    end
    trip_next = trip_reg;
    for (int r = 0; r < 3; r++) begin
      if (relay_and[r]) begin
        cond[r] = (relay_map[r*6 +: 6] != 6'h0) &&
                  ((relay_map[r*6 +: 6] & ~(conf_reg & lim_on)) == 6'h0);
      end else begin
        cond[r] = |(relay_map[r*6 +: 6] & conf_reg);
      end
      if (!hold_next) begin
        if (cond[r]) begin
          trip_next[r] = 1'b1;
        end else if (!relay_latch[r] || rst_p) begin
          trip_next[r] = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trip_reg <= 3'h0;
      hold_reg <= 1'b0;
    end else begin
      trip_reg <= trip_next;
      hold_reg <= hold_next;
    end
  end

  // Event log: write pointer, count, running number
  logic [6:0] wp_reg, wp_next, cnt_reg, cnt_next, run_reg, run_next;
  logic pwr_reg, pwr_next;
  logic ev_we;
  logic [23:0] ev_data;
  logic [6:0] rd_addr;
  logic [7:0] ev_code;
  always_comb begin
    ev_we = 1'b0;
    ev_code = 8'h0;
    if (pwr_reg) begin
      ev_we = 1'b1;
      ev_code = {`VLM_EV_PWRUP, 4'h0};
    end else if (fault_p) begin
      ev_we = 1'b1;
      ev_code = {`VLM_EV_ERROR, 4'h0};
    end else if (rst_p) begin
      ev_we = 1'b1;
      ev_code = {`VLM_EV_RESET, 4'h0};
    end else if (|conf_set) begin
      ev_we = 1'b1;
      for (int k = 5; k >= 0; k--) begin
        if (conf_set[k]) ev_code = {`VLM_EV_LIMIT, 4'(k)};
      end
    end
    ev_data = {`VLM_HIST_CHAR, 1'b0, run_reg, ev_code};
    pwr_next = 1'b0;
    wp_next = wp_reg;
    cnt_next = cnt_reg;
    run_next = run_reg;
    if (clr_p) begin
      wp_next = 7'h0;
      cnt_next = 7'h0;
      run_next = 7'h1;
      ev_we = 1'b0;
    end else if (ev_we) begin
      wp_next = (wp_reg == 7'(`VLM_LOG_DEPTH - 1)) ? 7'h0 : wp_reg + 7'h1;
      if (cnt_reg != 7'(`VLM_LOG_DEPTH)) cnt_next = cnt_reg + 7'h1;
      run_next = (run_reg == 7'(`VLM_LOG_DEPTH)) ? 7'h1 : run_reg + 7'h1;
    end
    // Index 0 reads the oldest entry
    if (cnt_reg == 7'(`VLM_LOG_DEPTH)) begin
      rd_addr = (8'(wp_reg) + 8'(log_rd_idx) >= 8'(`VLM_LOG_DEPTH)) ?
                7'(8'(wp_reg) + 8'(log_rd_idx) - 8'(`VLM_LOG_DEPTH)) :
                wp_reg + log_rd_idx;
    end else begin
      rd_addr = (log_rd_idx < 7'(`VLM_LOG_DEPTH)) ? log_rd_idx : 7'h0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg <= 7'h0;
      cnt_reg <= 7'h0;
      run_reg <= 7'h1;
      pwr_reg <= 1'b1;
    end else begin
      wp_reg <= wp_next;
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      pwr_reg <= pwr_next;
    end
  end

  // Log storage
  vlm_log_mem #(.DEPTH(`VLM_LOG_DEPTH), .WIDTH(24), .AW(7)) u_log (
    .clk_sys(clk_sys),
    .wr_en(ev_we),
    .wr_addr(wp_reg),
    .wr_data(ev_data),
    .rd_addr(rd_addr),
    .rd_data(log_rd_data)
  );

  // Registered outputs with energise polarity
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      alarm_relay_one <= 1'b0;
      alarm_relay_two <= 1'b0;
      alarm_relay_three <= 1'b0;
      lim_err <= 1'b0;
      meas_chan_b <= 1'b0;
      meas_active <= 1'b0;
      brg_measuring <= 1'b0;
      log_count <= 7'h0;
    end else begin
      alarm_relay_one <= trip_reg[0] ^ relay_energ[0];
      alarm_relay_two <= trip_reg[1] ^ relay_energ[1];
      alarm_relay_three <= trip_reg[2] ^ relay_energ[2];
      lim_err <= err_reg;
      meas_chan_b <= (mux_reg == VLM_SETTLE_B) || win_b;
      meas_active <= win_a || win_b;
      brg_measuring <= (brg_reg == VLM_BRG_MEAS);
      log_count <= cnt_reg;
    end
  end
endmodule : vlm_monitor

/* File: tb/vlm_monitor_sva.sv */
// Port assertions of the vibration limit alarm monitor
`timescale 1ns/1ps
`include "vlm_regs.svh"
module vlm_monitor_sva #(
  parameter int TICK_CYC = 20,
  parameter int VW = 10
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [5:0] func_a,
  input wire logic [5:0] func_b,
  input wire logic [VW-1:0] range_a,
  input wire logic [VW-1:0] range_b,
  input wire logic [VW-1:0] brg_range,
  input wire logic lim_wr,
  input wire logic [2:0] lim_sel,
  input wire logic [VW-1:0] lim_val,
  input wire logic [6:0] lim_dly,
  input wire logic health_fault,
  input wire logic alarm_relay_one,
  input wire logic alarm_relay_two,
  input wire logic alarm_relay_three,
  input wire logic lim_err,
  input wire logic meas_chan_b,
  input wire logic meas_active,
  input wire logic brg_measuring,
  input wire logic [6:0] log_count
);
  localparam int SET_Q [6] = '{`VLM_SET_HP1_Q, `VLM_SET_HP3_Q, `VLM_SET_HP10_Q,
    `VLM_SET_SPEC_Q, `VLM_SET_INT_Q, `VLM_SET_LIN_Q};
  int win_cnt; // Cycles since meas_active changed
  int brg_cnt; // Cycles since brg_measuring changed
  logic act_d, brg_d, seen_v, seen_b, last_b;
  logic [VW-1:0] rng; // Full scale of the addressed limit
  logic wr_ok; // Limit write within every bound

  // Longest settling among active functions, one tick when none
  function automatic int settle_q(input logic [5:0] f);
    int q;
    q = 1;
    for (int i = 0; i < 6; i++) begin
      if (f[i] && SET_Q[i] > q) begin
        q = SET_Q[i];
      end
    end
    return q;
  endfunction : settle_q

  // Acceptance of a limit write
  always_comb begin
    rng = (lim_sel == 3'h2 || lim_sel == 3'h5) ? brg_range : (lim_sel < 3'h3 ? range_a : range_b);
    wr_ok = lim_sel <= 3'h5 && lim_dly >= 7'h01 && lim_dly <= 7'h63 && lim_val * 10 >= rng
      && lim_val <= rng;
  end

  // Run lengths of window and bearing levels, last measured channel
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      win_cnt <= 0;
      brg_cnt <= 0;
      act_d <= 1'b0;
      brg_d <= 1'b0;
      seen_v <= 1'b0;
      seen_b <= 1'b0;
      last_b <= 1'b0;
    end else begin
      act_d <= meas_active;
      brg_d <= brg_measuring;
      win_cnt <= (meas_active != act_d) ? 0 : win_cnt + 1;
      brg_cnt <= (brg_measuring != brg_d) ? 0 : brg_cnt + 1;
      if (meas_active) begin
        last_b <= meas_chan_b;
      end
      if (act_d && !meas_active) begin
        seen_v <= 1'b1;
      end
      if (brg_d && !brg_measuring) begin
        seen_b <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_WIN_LEN: assert property ($fell(meas_active) |->
    win_cnt == `VLM_MEAS_Q * TICK_CYC - 1) else $error("measuring window length wrong");
  AST_SETTLE: assert property ($rose(meas_active) && seen_v |->
    win_cnt == settle_q(meas_chan_b ? func_b : func_a) * TICK_CYC - 1)
    else $error("settling length wrong");
  AST_ALT: assert property ($rose(meas_active) && seen_v |-> meas_chan_b != last_b)
    else $error("channels do not alternate");
  AST_BRG_MEAS: assert property ($fell(brg_measuring) |->
    brg_cnt == `VLM_BRG_MEAS_Q * TICK_CYC - 1) else $error("bearing window wrong");
  AST_BRG_SET: assert property ($rose(brg_measuring) && seen_b |->
    brg_cnt == `VLM_BRG_SET_Q * TICK_CYC - 1) else $error("bearing settling wrong");
  AST_LIM_BAD: assert property (lim_wr && !wr_ok |-> ##2 lim_err)
    else $error("bad limit write not flagged");
  AST_LIM_GOOD: assert property (lim_wr && wr_ok |-> ##2 !lim_err)
    else $error("good limit write flagged");
  AST_LOG_STEP: assert property ($changed(log_count) |-> log_count <= 7'h01
    || (log_count == $past(log_count) + 7'h01 && log_count <= 7'h63))
    else $error("log count step wrong");
  AST_FREEZE: assert property (health_fault [*6] |->
    $stable({alarm_relay_one, alarm_relay_two, alarm_relay_three}))
    else $error("relay moved during fault");
endmodule : vlm_monitor_sva

/* File: tb/vlm_xducer.sv */
// Transducer front end model feeding processed values
`timescale 1ns/1ps
module vlm_xducer #(
  parameter int VW = 10
) (
  input wire logic clk_sys,
  input wire logic [VW-1:0] lvl_a,
  input wire logic [VW-1:0] lvl_b,
  output logic [VW-1:0] meas_a,
  output logic [VW-1:0] meas_b,
  output logic [VW-1:0] brg_a,
  output logic [VW-1:0] brg_b
);
  // Fresh value every clock; bearing value at half the vibration level
  always_ff @(posedge clk_sys) begin
    meas_a <= lvl_a;
    meas_b <= lvl_b;
    brg_a <= lvl_a >> 1;
    brg_b <= lvl_b >> 1;
  end
endmodule : vlm_xducer

/* File: tb/vlm_monitor_test.sv */
// Self-checking bench of the vibration limit alarm monitor
`timescale 1ns/1ps
`include "vlm_regs.svh"
module vlm_monitor_test;
  localparam int TK = 20; // Short quarter-second tick
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic two_chan, lim_wr, relay_reset, log_clear, health_fault, lim_err;
  logic alarm_relay_one, alarm_relay_two, alarm_relay_three, meas_chan_b, meas_active;
  logic brg_measuring;
  logic [5:0] func_a, func_b, lim_on;
  logic [9:0] lvl_a, lvl_b, meas_a, meas_b, brg_a, brg_b, range_a, range_b, brg_range;
  logic [9:0] lim_val, v;
  logic [2:0] lim_sel, relay_and, relay_latch, relay_energ, s, rly;
  logic [6:0] lim_dly, log_rd_idx, log_count, d;
  logic [17:0] relay_map;
  logic [23:0] log_rd_data, ent;
  logic exp_q[$];
  int miscompares = 0;
  int compares = 0;
  int wn; // Cycles counted across one window
  int seed = 32'hb7444ad3;

  assign rly = {alarm_relay_three, alarm_relay_two, alarm_relay_one};
  always #25 clk_sys = ~clk_sys;

  vlm_xducer i_vlm_xducer (.*);
  vlm_monitor #(.TICK_CYC(TK)) i_vlm_monitor (.*);

  // Closing report
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_up(input string what);
    miscompares++;
    $display("BAD %s expected done seen timeout", what);
    give_verdict();
  endtask : give_up

  task automatic tick(input int n);
    repeat (n * TK) @(posedge clk_sys);
  endtask : tick

  // Start of a fresh window of the given channel
  task automatic wait_win(input logic b);
    int n;
    n = 0;
    while (meas_active !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    while ((meas_active !== 1'b1 || meas_chan_b !== b) && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) begin
      give_up("window");
    end
  endtask : wait_win

  task automatic wait_rly(input int k, input logic val);
    int n;
    n = 0;
    while (rly[k] !== val && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) begin
      give_up("relay");
    end
    chk("relay level", val, rly[k]);
  endtask : wait_rly

  task automatic wr_lim(input logic [2:0] ws, input logic [9:0] wv, input logic [6:0] wd);
    @(posedge clk_sys);
    lim_wr <= 1'b1;
    lim_sel <= ws;
    lim_val <= wv;
    lim_dly <= wd;
    @(posedge clk_sys);
    lim_wr <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : wr_lim

  task automatic rd_log(input logic [6:0] i);
    @(posedge clk_sys);
    log_rd_idx <= i;
    repeat (3) @(posedge clk_sys);
    ent = log_rd_data;
  endtask : rd_log

  task automatic pulse_reset();
    relay_reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    relay_reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : pulse_reset

  // Expected refusal of a limit write
  function automatic logic lim_bad(input logic [2:0] fs, input logic [9:0] fv,
    input logic [6:0] fd);
    int r;
    r = (fs == 3'h2 || fs == 3'h5) ? brg_range : (fs < 3'h3 ? range_a : range_b);
    return !(fs <= 3'h5 && fd >= 7'h01 && fd <= 7'h63 && fv * 10 >= r && fv <= r);
  endfunction : lim_bad

  // Main sequence
  initial begin
    {two_chan, lim_wr, relay_reset, log_clear, health_fault} = 5'h10;
    {func_a, func_b, lim_sel, lim_val, lim_dly, log_rd_idx} = '0;
    {range_a, range_b, brg_range, lvl_a, lvl_b} = {10'h200, 10'h200, 10'h3ff, 10'h080, 10'h080};
    lim_on = 6'h09;
    relay_map = {6'h09, 6'h01, 6'h01};
    {relay_and, relay_latch, relay_energ} = {3'h4, 3'h2, 3'h2};
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd_log(7'h00);
    chk("log count", 7'h01, log_count);
    chk("power-up entry", {8'h48, 7'h01, `VLM_EV_PWRUP}, {ent[23:16], ent[14:4]});
    $display("test power-up log done");
    for (int i = 0; i < 45; i++) begin
      s = 3'($random(seed));
      v = 10'($random(seed));
      d = 7'($random(seed));
      if (i == 0) {s, v, d} = {3'h0, 10'h200, 7'h63};
      if (i == 1) {s, v} = {3'h3, 10'h201};
      if (i == 2) {s, v, d} = {3'h1, 10'h034, 7'h00};
      if (i == 3) {s, v, d} = {3'h2, 10'h100, 7'h64};
      if (i == 4) {s, v, d} = {3'h6, 10'h100, 7'h01};
      if (i == 5) {s, v, d} = {3'h4, 10'h033, 7'h01};
      @(posedge clk_sys);
      lim_wr <= (i < 42);
      {lim_sel, lim_val, lim_dly} <= {s, v, d};
      if (i < 42) exp_q.push_back(lim_bad(s, v, d));
      if (i >= 3) chk("limit error", exp_q.pop_front(), lim_err);
    end
    wr_lim(3'h0, 10'h100, 7'h01);
    wr_lim(3'h3, 10'h100, 7'h01);
    chk("relays idle", 3'h2, rly);
    $display("test limit writes done");
    wait_win(1'b0);
    lvl_a <= 10'h180;
    tick(3);
    chk("early trip", 3'h2, rly);
    tick(5);
    chk("trip", 3'h1, rly);
    chk("log after trip", 7'h02, log_count);
    rd_log(log_count - 7'h01);
    chk("limit entry", {`VLM_EV_LIMIT, 4'h0}, ent[7:0]);
    lvl_a <= 10'h080;
    tick(2);
    chk("release", 3'h0, rly);
    $display("test relay trip done");
    health_fault <= 1'b1;
    lvl_a <= 10'h180;
    wait_win(1'b0);
    tick(8);
    chk("frozen", 3'h0, rly);
    lvl_a <= 10'h080;
    health_fault <= 1'b0;
    tick(2);
    chk("held after fault", 3'h0, rly);
    pulse_reset();
    chk("after reset", 3'h2, rly);
    rd_log(log_count - 7'h01);
    chk("reset entry", `VLM_EV_RESET, ent[7:4]);
    $display("test health fault done");
    {lvl_a, lvl_b} <= {10'h180, 10'h180};
    wait_rly(2, 1'b1);
    lim_on <= 6'h01;
    wait_rly(2, 1'b0);
    {lvl_a, lvl_b} <= {10'h080, 10'h080};
    lim_on <= 6'h09;
    wait_rly(0, 1'b0);
    pulse_reset();
    $display("test and combine done");
    wr_lim(3'h0, 10'h100, 7'h04);
    wait_win(1'b0);
    lvl_a <= 10'h180;
    wait_win(1'b1);
    chk("paused", 1'b0, alarm_relay_one);
    wait_rly(0, 1'b1);
    chk("resumed in own window", 2'h2, {meas_active, meas_chan_b});
    lvl_a <= 10'h080;
    wait_rly(0, 1'b0);
    wr_lim(3'h0, 10'h100, 7'h02);
    wait_win(1'b0);
    lvl_a <= 10'h180;
    tick(5);
    lvl_a <= 10'h080;
    tick(2);
    lvl_a <= 10'h180;
    tick(5);
    chk("drop restarts delay", 1'b0, alarm_relay_one);
    lvl_a <= 10'h080;
    $display("test delay pause done");
    log_clear <= 1'b1;
    repeat (4) @(posedge clk_sys);
    log_clear <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("cleared", 7'h00, log_count);
    repeat (101) pulse_reset();
    chk("log full", 7'h63, log_count);
    rd_log(7'h00);
    chk("oldest entry", {7'h03, `VLM_EV_RESET}, ent[14:4]);
    $display("test log wrap done");
    for (int i = 0; i < 6; i++) begin
      wait_win(1'b1);
      func_a <= 6'($random(seed));
      wait_win(1'b0);
      func_b <= 6'($random(seed));
    end
    wait_win(1'b1);
    wn = 0;
    while (meas_active === 1'b1 && wn < 3000) begin
      @(posedge clk_sys);
      wn++;
    end
    chk("window cycles", 24'(`VLM_MEAS_Q * TK), 24'(wn));
    wait_win(1'b0);
    two_chan <= 1'b0;
    tick(14);
    chk("single channel", 2'h2, {meas_active, meas_chan_b});
    $display("test settling done");
    give_verdict();
  end
endmodule : vlm_monitor_test

bind vlm_monitor vlm_monitor_sva #(.TICK_CYC(TICK_CYC), .VW(VW)) i_vlm_monitor_sva (.*);
